// [logic/tec_defs.vh]
/*
 * Constants for the 16-bit timer/event counter: register indices,
 * field positions, mode and clock-select codes, reset values.
 * Assumes inclusion by bare name from the logic/ and bench/ files.
 */
`ifndef TEC_DEFS_VH
`define TEC_DEFS_VH

// register indices on the plain register port
`define TEC_ADDR_W         3
`define TEC_DATA_W         16
`define TEC_ADDR_MODE      3'h0
`define TEC_ADDR_PRESCALE  3'h1
`define TEC_ADDR_CCCTRL    3'h2
`define TEC_ADDR_OUTCTRL   3'h3
`define TEC_ADDR_COUNT     3'h4
`define TEC_ADDR_CCZERO    3'h5
`define TEC_ADDR_CCONE     3'h6
`define TEC_ADDR_IRQMASK   3'h7

// mode_ctrl_reg fields
`define TEC_MODE_HI        3
`define TEC_MODE_LO        2
`define TEC_MODE_EDGETOG   1
`define TEC_MODE_STOP      2'h0
`define TEC_MODE_FREE      2'h1
`define TEC_MODE_EDGECLR   2'h2
`define TEC_MODE_MATCHCLR  2'h3

// prescale_mode_reg fields
`define TEC_CS_HI          1
`define TEC_CS_LO          0
`define TEC_ES0_HI         5
`define TEC_ES0_LO         4
`define TEC_ES1_HI         7
`define TEC_ES1_LO         6
`define TEC_CS_DIV1        2'h0
`define TEC_CS_DIV4        2'h1
`define TEC_CS_DIV256      2'h2
`define TEC_CS_EVENT       2'h3

// event edge select codes
`define TEC_ES_FALL        2'h0
`define TEC_ES_RISE        2'h1
`define TEC_ES_NONE        2'h2
`define TEC_ES_BOTH        2'h3

// cc_ctrl_reg fields
`define TEC_CC_ZERO_CAP    0
`define TEC_CC_REVERSE     1
`define TEC_CC_ONE_CAP     2

// out_ctrl_reg fields
`define TEC_OUT_ENABLE     0
`define TEC_OUT_TOG_ZERO   1
`define TEC_OUT_TOG_ONE    4

// irq mask register fields
`define TEC_MASK_ZERO      0
`define TEC_MASK_ONE       1

// prescaler
`define TEC_PRE_W          8
`define TEC_PRE_DIV4_MASK  8'h03
`define TEC_PRE_DIV256     8'hFF

// reset values
`define TEC_RST_CTRL       8'h00
`define TEC_RST_WORD       16'h0000
`define TEC_RST_PRE        8'h00
`define TEC_RST_MASK       2'h0
`define TEC_COUNT_ONE      16'h0001

`endif

// [logic/tec_edge_det.v]
/*
 * Noise-filtered edge detector for one timer input pin.
 * Assumes the pin is already synchronous to clk; a level change is only
 * believed after it has been seen on two samples in a row.
 */
`include "tec_defs.vh"

module tec_edge_det (
	input  wire       clk,
	input  wire       reset_n,
	input  wire       pinIn,
	input  wire [1:0] edgeSel,
	output reg        validEdge,
	output reg        reverseEdge
);

	reg  histA_q;
	reg  histB_q;
	reg  level_q;
	wire stable;
	wire rise;
	wire fall;

	// two equal samples that differ from the accepted level make an edge
	assign stable = (histA_q == histB_q) && (histA_q != level_q);
	assign rise   = stable && histA_q;
	assign fall   = stable && !histA_q;

	// sample history and accepted level; outputs are one-cycle pulses
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			histA_q     <= 1'b0;
			histB_q     <= 1'b0;
			level_q     <= 1'b0;
			validEdge   <= 1'b0;
			reverseEdge <= 1'b0;
		end else begin
			histA_q <= pinIn;
			histB_q <= histA_q;
			if (stable) begin
				level_q <= histA_q;
			end
			case (edgeSel)
				`TEC_ES_FALL: begin
					validEdge   <= fall;
					reverseEdge <= rise;
				end
				`TEC_ES_RISE: begin
					validEdge   <= rise;
					reverseEdge <= fall;
				end
				`TEC_ES_BOTH: begin
					validEdge   <= stable;
					reverseEdge <= 1'b0; // no opposite phase when both edges count
				end
				default: begin
					validEdge   <= 1'b0;
					reverseEdge <= 1'b0;
				end
			endcase
		end
	end

endmodule

// [logic/tec_timer.v]
/*
 * 16-bit timer/event counter: prescaler, counter, two capture/compare
 * registers, timer output and two match/capture pulses.
 * Assumes a single 25 MHz clock, pins synchronous to it, and a master on
 * the plain register port that keeps strobes one cycle long.
 * Assumes software keeps cc zero non-zero in the match-clear mode and never
 * picks the event clock in edge-clear mode; neither misuse is trapped here.
 */
`include "tec_defs.vh"

module tec_timer (
	input  wire                      clk,
	input  wire                      reset_n,
	input  wire [`TEC_ADDR_W-1:0]    regAddr,
	input  wire [`TEC_DATA_W-1:0]    regWrData,
	input  wire                      regWr,
	input  wire                      regRd,
	output reg  [`TEC_DATA_W-1:0]    regRdData,
	input  wire                      eventInputPin,
	input  wire                      secondCapturePin,
	output reg                       timerOutputPin,
	output reg                       matchIrqZero,
	output reg                       matchIrqOne
);

	reg  [7:0]             modeCtrl_q;
	reg  [7:0]             prescaleMode_q;
	reg  [7:0]             ccCtrl_q;
	reg  [7:0]             outCtrl_q;
	reg  [1:0]             irqMask_q;
	reg  [`TEC_DATA_W-1:0] count_q;
	reg  [`TEC_DATA_W-1:0] ccZero_q;
	reg  [`TEC_DATA_W-1:0] ccOne_q;
	reg  [`TEC_PRE_W-1:0]  pre_q;
	reg                    starting_q;
	reg                    outLevel_q;
	reg  [`TEC_DATA_W-1:0] count_d;
	reg                    tick;
	reg  [`TEC_DATA_W-1:0] rdMux;

	wire [1:0] opMode;
	wire [1:0] clockSel;
	wire       eventEdge;
	wire       eventReverse;
	wire       secondEdge;
	wire       running;
	wire       zeroIsCap;
	wire       oneIsCap;
	wire       eqZero;
	wire       eqOne;
	wire       matchZero;
	wire       matchOne;
	wire       capZero;
	wire       capOne;
	wire       edgeClear;
	wire       hitZero;
	wire       hitOne;
	wire       toggle;
	wire       togZero;
	wire       togOne;
	wire       togEdge;
	wire       matchClear;
	wire       wrMode;
	wire       wrPrescale;
	wire       wrCcCtrl;
	wire       wrOutCtrl;
	wire       wrMask;
	wire       wrCcZero;
	wire       wrCcOne;

	assign opMode    = modeCtrl_q[`TEC_MODE_HI:`TEC_MODE_LO];
	assign clockSel  = prescaleMode_q[`TEC_CS_HI:`TEC_CS_LO];
	assign running   = (opMode != `TEC_MODE_STOP);
	assign zeroIsCap = ccCtrl_q[`TEC_CC_ZERO_CAP];
	assign oneIsCap  = ccCtrl_q[`TEC_CC_ONE_CAP];
	assign wrMode    = regWr && (regAddr == `TEC_ADDR_MODE);

	// one write decode per register; index 4 has none, so count writes fall away
	assign wrPrescale = regWr && (regAddr == `TEC_ADDR_PRESCALE);
	assign wrCcCtrl   = regWr && (regAddr == `TEC_ADDR_CCCTRL);
	assign wrOutCtrl  = regWr && (regAddr == `TEC_ADDR_OUTCTRL);
	assign wrMask     = regWr && (regAddr == `TEC_ADDR_IRQMASK);
	assign wrCcZero   = regWr && (regAddr == `TEC_ADDR_CCZERO);
	assign wrCcOne    = regWr && (regAddr == `TEC_ADDR_CCONE);

	// filtered edge detectors for the event pin and the second capture pin
	tec_edge_det uEventEdge (
		.clk         (clk),
		.reset_n     (reset_n),
		.pinIn       (eventInputPin),
		.edgeSel     (prescaleMode_q[`TEC_ES0_HI:`TEC_ES0_LO]),
		.validEdge   (eventEdge),
		.reverseEdge (eventReverse)
	);

	tec_edge_det uSecondEdge (
		.clk         (clk),
		.reset_n     (reset_n),
		.pinIn       (secondCapturePin),
		.edgeSel     (prescaleMode_q[`TEC_ES1_HI:`TEC_ES1_LO]),
		.validEdge   (secondEdge),
		.reverseEdge ()
	);

	// free-running prescaler; it never stops so the count clock phase is stable
	// limitation: a clock-select change mid-run may shorten the first count period
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_q <= `TEC_RST_PRE;
		end else begin
			pre_q <= pre_q + 8'h01;
		end
	end

	// count clock select: divided peripheral clock or event pin valid edge
	always @* begin
		case (clockSel)
			`TEC_CS_DIV1:   tick = 1'b1;
			`TEC_CS_DIV4:   tick = ((pre_q & `TEC_PRE_DIV4_MASK) == `TEC_PRE_DIV4_MASK);
			`TEC_CS_DIV256: tick = (pre_q == `TEC_PRE_DIV256);
			`TEC_CS_EVENT:  tick = eventEdge;
			default:        tick = 1'b0;
		endcase
	end

	// comparisons look at the settled count on the count clock
	assign eqZero    = (count_q == ccZero_q);
	assign eqOne     = (count_q == ccOne_q);
	assign matchZero = running && tick && !starting_q && !zeroIsCap && eqZero;
	assign matchOne  = running && tick && !starting_q && !oneIsCap && eqOne;

	// mode decodes; capture triggers only act in the edge-clear mode
	assign edgeClear  = (opMode == `TEC_MODE_EDGECLR);
	assign matchClear = (opMode == `TEC_MODE_MATCHCLR);

	// with both edges selected there is no opposite phase, so reverse capture stays idle
	assign capZero   = edgeClear && zeroIsCap &&
		(ccCtrl_q[`TEC_CC_REVERSE] ? eventReverse : secondEdge);
	assign capOne    = edgeClear && oneIsCap && eventEdge;

	// interrupt causes; reverse-phase capture is silent, second pin still counts
	assign hitZero = matchZero || (edgeClear && zeroIsCap && secondEdge);
	assign hitOne  = matchOne || capOne;

	// output inversion causes; causes in one cycle merge into a single inversion
	assign togZero = matchZero && outCtrl_q[`TEC_OUT_TOG_ZERO];
	assign togOne  = matchOne && outCtrl_q[`TEC_OUT_TOG_ONE];
	assign togEdge = edgeClear && eventEdge && modeCtrl_q[`TEC_MODE_EDGETOG];
	assign toggle  = togZero || togOne || togEdge;

	// next count value by mode
	// an event clear beats a tick in the same cycle, so a clear is never lost
	always @* begin
		count_d = count_q;
		if (!running) begin
			count_d = `TEC_RST_WORD;
		end else if (edgeClear && eventEdge) begin
			count_d = `TEC_RST_WORD;
		end else if (tick) begin
			if (starting_q) begin
				count_d = count_q;
			end else if (matchClear && eqZero) begin
				count_d = `TEC_RST_WORD;
			end else begin
				count_d = count_q + `TEC_COUNT_ONE;
			end
		end
	end

	// counter and start flag; the first count clock after start only syncs
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_q    <= `TEC_RST_WORD;
			starting_q <= 1'b1;
		end else begin
			count_q <= count_d;
			if (!running) begin
				starting_q <= 1'b1;
			end else if (tick) begin
				starting_q <= 1'b0;
			end
		end
	end

	// control registers written from the register port
	// these registers are eight bits wide, the mask two; upper write data bits are dropped on purpose
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			modeCtrl_q     <= `TEC_RST_CTRL;
			prescaleMode_q <= `TEC_RST_CTRL;
			ccCtrl_q       <= `TEC_RST_CTRL;
			outCtrl_q      <= `TEC_RST_CTRL;
			irqMask_q      <= `TEC_RST_MASK;
		end else begin
			if (wrMode) begin
				modeCtrl_q <= regWrData[7:0];
			end
			if (wrPrescale) begin
				prescaleMode_q <= regWrData[7:0];
			end
			if (wrCcCtrl) begin
				ccCtrl_q <= regWrData[7:0];
			end
			if (wrOutCtrl) begin
				outCtrl_q <= regWrData[7:0];
			end
			if (wrMask) begin
				irqMask_q <= regWrData[1:0];
			end
		end
	end

	// capture/compare registers; a capture beats a software write
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ccZero_q <= `TEC_RST_WORD;
			ccOne_q  <= `TEC_RST_WORD;
		end else begin
			if (capZero) begin
				ccZero_q <= count_q;
			end else if (wrCcZero && !zeroIsCap) begin
				ccZero_q <= regWrData;
			end
			if (capOne) begin
				ccOne_q <= count_q;
			end else if (wrCcOne && !oneIsCap) begin
				ccOne_q <= regWrData;
			end
		end
	end

	// timer output: toggles while enabled, forced low when disabled or stopped
	// the pin follows the internal level a cycle later, so it lags the pulses by one
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			outLevel_q     <= 1'b0;
			timerOutputPin <= 1'b0;
		end else begin
			if (!outCtrl_q[`TEC_OUT_ENABLE] || wrMode) begin
				outLevel_q <= 1'b0;
			end else if (toggle) begin
				outLevel_q <= !outLevel_q;
			end
			timerOutputPin <= outLevel_q;
		end
	end

	// interrupt pulses, one cycle per event, gated by the mask bits
	// there is no pending flag, so an event seen while masked is lost
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			matchIrqZero <= 1'b0;
			matchIrqOne  <= 1'b0;
		end else begin
			matchIrqZero <= hitZero && !irqMask_q[`TEC_MASK_ZERO];
			matchIrqOne  <= hitOne && !irqMask_q[`TEC_MASK_ONE];
		end
	end

	// read multiplexer; control registers read back with zero upper bits
	always @* begin
		case (regAddr)
			`TEC_ADDR_MODE:     rdMux = {8'h00, modeCtrl_q};
			`TEC_ADDR_PRESCALE: rdMux = {8'h00, prescaleMode_q};
			`TEC_ADDR_CCCTRL:   rdMux = {8'h00, ccCtrl_q};
			`TEC_ADDR_OUTCTRL:  rdMux = {8'h00, outCtrl_q};
			`TEC_ADDR_COUNT:    rdMux = count_q;
			`TEC_ADDR_CCZERO:   rdMux = ccZero_q;
			`TEC_ADDR_CCONE:    rdMux = ccOne_q;
			`TEC_ADDR_IRQMASK:  rdMux = {14'h0000, irqMask_q};
			default:            rdMux = `TEC_RST_WORD;
		endcase
	end

	// read data stand only in the cycle after the strobe; reads have no side effect
	// a plain snapshot of the count, so a read never stalls or restarts counting
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			regRdData <= `TEC_RST_WORD;
		end else if (regRd) begin
			regRdData <= rdMux;
		end else begin
			regRdData <= `TEC_RST_WORD;
		end
	end

endmodule

// [bench/tec_pin_model.sv]
/* pin model for the event input and the second capture input.
   assumes the bench calls flip() only from its own procedural flow. */
module tec_pin_model (
	input  wire  clk,
	output logic eventInputPin,
	output logic secondCapturePin
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle levels: event low, second pin high so its first move is a fall
	initial begin
		eventInputPin = 1'b0;
		secondCapturePin = 1'b1;
	end

	// invert one pin after an edge and hold it; a hold of 1 is noise
	task automatic flip(input bit sel, input int hold);
		@(posedge clk);
		if (sel)
			secondCapturePin <= ~secondCapturePin;
		else
			eventInputPin <= ~eventInputPin;
		repeat (hold - 1) @(posedge clk);
	endtask
endmodule

// [bench/tec_timer_checker.sv]
/* assertions on the timer ports: pulse length, reset, read port, stop,
   output enable and mask. assumes a bind from the bench top file. */
`include "tec_defs.vh"
module tec_timer_checker (
	input wire                   clk,
	input wire                   reset_n,
	input wire [`TEC_ADDR_W-1:0] regAddr,
	input wire [`TEC_DATA_W-1:0] regWrData,
	input wire                   regWr,
	input wire                   regRd,
	input wire [`TEC_DATA_W-1:0] regRdData,
	input wire                   eventInputPin,
	input wire                   secondCapturePin,
	input wire                   timerOutputPin,
	input wire                   matchIrqZero,
	input wire                   matchIrqOne
);
	logic stopMode_q;
	logic outEn_q;
	logic maskOne_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// shadow of the few control bits; only register writes move them
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stopMode_q <= 1'b1;
			outEn_q <= 1'b0;
			maskOne_q <= 1'b0;
		end else if (regWr) begin
			if (regAddr == `TEC_ADDR_MODE)
				stopMode_q <= (regWrData[3:2] == `TEC_MODE_STOP);
			if (regAddr == `TEC_ADDR_OUTCTRL)
				outEn_q <= regWrData[`TEC_OUT_ENABLE];
			if (regAddr == `TEC_ADDR_IRQMASK)
				maskOne_q <= regWrData[`TEC_MASK_ONE];
		end
	end

	irq0_single_a: assert property (matchIrqZero |=> !matchIrqZero)
		else $error("first interrupt longer than one cycle");
	irq1_single_a: assert property (matchIrqOne |=> !matchIrqOne)
		else $error("second interrupt longer than one cycle");
	reset_quiet_a: assert property ($rose(reset_n) |->
		!matchIrqZero && !matchIrqOne && !timerOutputPin && regRdData == 16'h0000)
		else $error("outputs not quiet after reset");
	rd_idle_zero_a: assert property (!$past(regRd) |-> regRdData == 16'h0000)
		else $error("read data outside its cycle");
	stop_read_a: assert property (stopMode_q && regRd && regAddr == `TEC_ADDR_COUNT
		|=> regRdData == 16'h0000)
		else $error("stopped counter not zero");
	stop_quiet_a: assert property (regWr && regAddr == `TEC_ADDR_MODE
		&& regWrData[3:2] == `TEC_MODE_STOP
		|-> ##3 (!matchIrqZero && !matchIrqOne && !timerOutputPin) [*4])
		else $error("activity after stop");
	out_off_low_a: assert property (!outEn_q [*4] |-> !timerOutputPin)
		else $error("output high while disabled");
	irq_masked_a: assert property (maskOne_q [*4] |-> !matchIrqOne)
		else $error("masked second interrupt seen");

	cover property (matchIrqZero);
	cover property (matchIrqOne);
	cover property ($changed(timerOutputPin));
endmodule

// [bench/tb_timer_event_counter_16bit.sv]
/* self-checking bench for the timer: register tasks, scenarios, verdict.
   assumes the pin model and checker files are compiled before this one. */
`include "tec_defs.vh"
module tb_timer_event_counter_16bit;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [2:0]  regAddr = 3'h0;
	logic [15:0] regWrData = 16'h0000;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	wire  [15:0] regRdData;
	wire         eventInputPin, secondCapturePin, timerOutputPin, matchIrqZero, matchIrqOne;
	int          bad_count = 0, comparisons = 0, irq0Cnt = 0, irq1Cnt = 0, togCnt = 0;
	int          cyc = 0, last0 = 0, last1 = 0, gap0 = 0, gap1 = 0;
	logic        outPrev = 1'b0;
	logic [15:0] v, w;

	always #20 clk = ~clk;

	tec_pin_model pins (.clk(clk), .eventInputPin(eventInputPin),
		.secondCapturePin(secondCapturePin));
	tec_timer dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .eventInputPin(eventInputPin),
		.secondCapturePin(secondCapturePin), .timerOutputPin(timerOutputPin),
		.matchIrqZero(matchIrqZero), .matchIrqOne(matchIrqOne));

	// pulse and toggle bookkeeping; scenarios read it only at falling edges
	always @(posedge clk) begin
		cyc++;
		if (matchIrqZero === 1'b1) begin
			irq0Cnt++;
			gap0 = cyc - last0;
			last0 = cyc;
		end
		if (matchIrqOne === 1'b1) begin
			irq1Cnt++;
			gap1 = cyc - last1;
			last1 = cyc;
		end
		if (timerOutputPin !== outPrev)
			togCnt++;
		outPrev = timerOutputPin;
	end

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		d = regRdData;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		if (bad_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chkReset;
		for (int a = 0; a < 8; a++) begin
			rd(a[2:0], v);
			cmp(v, 16'h0000);
		end
	endtask

	// match-clear mode, M = 3 on the undivided clock: period of 4 cycles
	task automatic chkInterval;
		wr(`TEC_ADDR_CCZERO, 16'h0003);
		wr(`TEC_ADDR_CCONE, 16'h0002);
		wr(`TEC_ADDR_OUTCTRL, 16'h0003);
		wr(`TEC_ADDR_MODE, 16'h000C);
		idle(12);
		irq0Cnt = 0;
		togCnt = 0;
		idle(40);
		cmp(16'(irq0Cnt), 16'h000A);
		cmp(16'(gap0), 16'h0004);
		cmp(16'(togCnt), 16'h000A);
		cmp(16'(gap1), 16'h0004);
		// toggle on both compare matches: two inversions per period of 4
		wr(`TEC_ADDR_OUTCTRL, 16'h0013);
		idle(4);
		togCnt = 0;
		idle(40);
		cmp(16'(togCnt), 16'h0014);
		rd(`TEC_ADDR_COUNT, v);
		cmp(16'(v <= 16'h0003), 16'h0001);
		// back-to-back reads sample two cycles apart; the count keeps stepping
		rd(`TEC_ADDR_COUNT, w);
		cmp(w, (v + 16'h0002) & 16'h0003);
		// divided count clocks: M + 1 = 4 ticks of 4 and of 256 cycles
		wr(`TEC_ADDR_PRESCALE, 16'h0001);
		idle(48);
		cmp(16'(gap0), 16'h0010);
		wr(`TEC_ADDR_PRESCALE, 16'h0002);
		idle(2400);
		cmp(16'(gap0), 16'h0400);
		wr(`TEC_ADDR_PRESCALE, 16'h0000);
		wr(`TEC_ADDR_IRQMASK, 16'h0002);
		idle(4);
		irq1Cnt = 0;
		idle(20);
		cmp(16'(irq1Cnt), 16'h0000);
		wr(`TEC_ADDR_MODE, 16'h0000);
		idle(4);
		irq0Cnt = 0;
		idle(20);
		rd(`TEC_ADDR_COUNT, v);
		cmp(v, 16'h0000);
		cmp(16'(irq0Cnt), 16'h0000);
		wr(`TEC_ADDR_IRQMASK, 16'h0000);
	endtask

	// counting rising event edges with M = 2; two noise pulses in between
	task automatic chkEvent;
		wr(`TEC_ADDR_PRESCALE, 16'h0013);
		wr(`TEC_ADDR_CCZERO, 16'h0002);
		wr(`TEC_ADDR_MODE, 16'h000C);
		idle(4);
		irq0Cnt = 0;
		repeat (3) begin
			pins.flip(0, 4);
			pins.flip(0, 4);
		end
		repeat (2) begin
			pins.flip(0, 1);
			pins.flip(0, 4);
		end
		idle(6);
		cmp(16'(irq0Cnt), 16'h0000);
		pins.flip(0, 4);
		pins.flip(0, 4);
		idle(6);
		cmp(16'(irq0Cnt), 16'h0001);
		repeat (3) begin
			pins.flip(0, 4);
			pins.flip(0, 4);
		end
		idle(6);
		cmp(16'(irq0Cnt), 16'h0002);
		// both edges count: three single flips reach M + 1 = 3 ticks
		wr(`TEC_ADDR_PRESCALE, 16'h0033);
		repeat (3) pins.flip(0, 4);
		idle(6);
		cmp(16'(irq0Cnt), 16'h0003);
		// no edge selected: flips must not count at all
		wr(`TEC_ADDR_PRESCALE, 16'h0023);
		repeat (3) pins.flip(0, 4);
		idle(6);
		cmp(16'(irq0Cnt), 16'h0003);
	endtask

	// edge-clear mode with both registers capturing and edge toggle on
	task automatic chkCapture;
		wr(`TEC_ADDR_MODE, 16'h0000);
		wr(`TEC_ADDR_PRESCALE, 16'h0010);
		wr(`TEC_ADDR_CCCTRL, 16'h0005);
		wr(`TEC_ADDR_OUTCTRL, 16'h0001);
		wr(`TEC_ADDR_MODE, 16'h000A);
		idle(40);
		irq0Cnt = 0;
		irq1Cnt = 0;
		togCnt = 0;
		pins.flip(0, 4);
		idle(4);
		rd(`TEC_ADDR_COUNT, v);
		rd(`TEC_ADDR_CCONE, w);
		cmp(16'(irq1Cnt), 16'h0001);
		cmp(16'(v < 16'h0010 && w > 16'h001E), 16'h0001);
		cmp(16'(togCnt), 16'h0001);
		pins.flip(1, 4);
		idle(4);
		cmp(16'(irq0Cnt), 16'h0001);
		rd(`TEC_ADDR_CCZERO, v);
		cmp(16'(v != 16'h0000), 16'h0001);
		wr(`TEC_ADDR_CCCTRL, 16'h0007);
		pins.flip(0, 4);
		idle(4);
		rd(`TEC_ADDR_CCZERO, w);
		cmp(16'(irq0Cnt), 16'h0001);
		cmp(16'(w != v), 16'h0001);
		pins.flip(1, 4);
		pins.flip(1, 4);
		idle(4);
		cmp(16'(irq0Cnt), 16'h0002);
	endtask

	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		chkReset;
		chkInterval;
		chkEvent;
		chkCapture;
		close_out;
	end

	// a hang counts as a mismatch and ends in the same verdict
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		close_out;
	end
endmodule

bind tec_timer tec_timer_checker chk (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
	.eventInputPin(eventInputPin), .secondCapturePin(secondCapturePin),
	.timerOutputPin(timerOutputPin), .matchIrqZero(matchIrqZero), .matchIrqOne(matchIrqOne));
